// ==== logic/accel_params.svh ====
// register offsets, field positions, reset values and codes of the config bank
// assumes inclusion by bare name from every design file that needs them
`ifndef ACCEL_CFG_PARAMS_SVH
`define ACCEL_CFG_PARAMS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define ADDR_LOCK_KEY 6'h1e
`define ADDR_INT_MASK 6'h21
`define ADDR_DATA_WIN 6'h22
`define ADDR_SELECT 6'h20
`define ADDR_STATUS 6'h02
// ----------------------------------------
// selector codes and key bytes
// ----------------------------------------
`define SEL_OUT_CFG 5'h0b
`define SEL_RESET 5'h00
`define KEY_BYTE0 8'h00
`define KEY_BYTE1 8'h50
`define KEY_BYTE2 8'ha0
// ----------------------------------------
// field positions
// ----------------------------------------
`define OC_X_EN 4
`define OC_Y_EN 3
`define OC_Z_EN 2
`define OC_RATE_HI 1
`define OC_RATE_LO 0
`define IM_FULL_EN 7
`define IM_HALF_EN 6
`define IM_MASK_ALL 1
`define IM_POLARITY 0
`define ST_LOCK_OPEN 0
// ----------------------------------------
// reset values and rate codes
// ----------------------------------------
`define OUT_CFG_RESET 8'h1c
`define OUT_CFG_MASK 8'h1f
`define INT_MASK_RESET 8'h41
`define INT_MASK_MASK 8'hc3
`define BYTE_ZERO 8'h00
`define RATE_DIV2 2'h1
`define RATE_DIV4 2'h2
`define DECIM_ZERO 2'h0
`define DECIM_ONE 2'h1
`define DECIM_THREE 2'h3
`endif

// ==== logic/accel_cfg_pkg.sv ====
// types shared by the config bank modules
// assumes accel_params.svh is available on the include path
package accel_cfg_pkg;
   // lock key progress
   typedef enum logic [1:0] {KEY_IDLE, KEY_GOT0, KEY_GOT1, KEY_OPEN} key_state_t;
endpackage : accel_cfg_pkg

// ==== logic/cfg_link_if.sv ====
// carrier between the config bank and its helper modules
// assumes a single clock domain shared by all users
`timescale 1ns/1ps
interface cfg_link_if;
   logic key_write; // one-cycle write to the lock key register
   logic [7:0] key_data; // byte written
   logic lock_open; // lock state
   logic sample_in; // new calibrated sample
   logic [1:0] rate; // decimation code
   logic store; // sample goes to ring buffer
   modport bank (output key_write, output key_data, input lock_open,
                 output sample_in, output rate, input store);
   modport lock (input key_write, input key_data, output lock_open);
   modport decim (input sample_in, input rate, output store);
endinterface : cfg_link_if

// ==== logic/key_lock.sv ====
// key sequence tracker for the register lock
// assumes writes arrive as one-cycle strobes on the link
`timescale 1ns/1ps
`include "accel_params.svh"
module key_lock
   import accel_cfg_pkg::*;
(
   input wire logic clock_i,
   input wire logic resetn_i,
   cfg_link_if.lock link
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      key_state_t st; // key progress
   } lock_t;
   lock_t r;
   lock_t next_r;

   // next state from key writes
   always_comb begin
      next_r = r;
      if (link.key_write) begin
         case (r.st)
            KEY_GOT0: next_r.st = (link.key_data == `KEY_BYTE1) ? KEY_GOT1 : KEY_IDLE;
            KEY_GOT1: next_r.st = (link.key_data == `KEY_BYTE2) ? KEY_OPEN : KEY_IDLE;
            default: next_r.st = (link.key_data == `KEY_BYTE0) ? KEY_GOT0 : KEY_IDLE;
         endcase
      end
   end

   // register state
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         r.st <= KEY_IDLE;
      end else begin
         r <= next_r;
      end
   end

   assign link.lock_open = (r.st == KEY_OPEN);
endmodule : key_lock

// ==== logic/buf_decimator.sv ====
// ring buffer load decimator
// assumes one-cycle sample strobes from the calibration path
`timescale 1ns/1ps
`include "accel_params.svh"
module buf_decimator
   import accel_cfg_pkg::*;
(
   input wire logic clock_i,
   input wire logic resetn_i,
   cfg_link_if.decim link
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic [1:0] cnt; // samples since last store
   } dec_t;
   dec_t r;
   dec_t next_r;
   logic [1:0] last; // count at which a sample is kept

   always_comb begin
      case (link.rate)
         `RATE_DIV2: last = `DECIM_ONE;
         `RATE_DIV4: last = `DECIM_THREE;
         default: last = `DECIM_ZERO;
      endcase
   end

   // count samples, wrap at divisor
   always_comb begin
      next_r = r;
      if (link.sample_in) begin
         next_r.cnt = (r.cnt >= last) ? `DECIM_ZERO : r.cnt + `DECIM_ONE;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         r.cnt <= `DECIM_ZERO;
      end else begin
         r <= next_r;
      end
   end

   assign link.store = link.sample_in && (r.cnt >= last);
endmodule : buf_decimator

// ==== logic/accel_config_lock_regs.sv ====
// configuration register bank: lock, pin mask, indirect window, output config
// assumes a serial slave front end delivering decoded register strobes
`timescale 1ns/1ps
`include "accel_params.svh"

// What this block does
// - bits 4,3,2 enable X,Y,Z buffer storing
// - rate code 10 quarter, 01 half
// - key bytes 00h 50h A0h open lock
// - any other key sequence closes lock
// - lock state readable in status
// - bit 7 three-quarter, bit 6 half enables
// - mask-all gates pin only, flags continue
// - mask-all blocks free-fall and motion too
// - unmasked pin follows individual enables
// - bit 0 selects pin polarity
// - window write stores into selected register only while lock open
// - window read returns selected register
// - only factory-chosen serial interface active
// - device is slave, never drives clock
// - dedicated interrupt output line
// - five-bit selector picks indirect register
// - selected register accessible immediately
module accel_config_lock_regs
   import accel_cfg_pkg::*;
(
   input wire logic clock_i, // 200 MHz core clock
   input wire logic resetn_i, // synchronous, active low
   input wire logic use_i2c_i, // factory strap: 1 selects two-wire port
   input wire logic spi_wr_i, // spi port write strobe
   input wire logic spi_rd_i, // spi port read strobe
   input wire logic [5:0] spi_addr_i, // spi port register address
   input wire logic [7:0] spi_wdata_i, // spi port write byte
   input wire logic i2c_wr_i, // two-wire port write strobe
   input wire logic i2c_rd_i, // two-wire port read strobe
   input wire logic [5:0] i2c_addr_i, // two-wire port register address
   input wire logic [7:0] i2c_wdata_i, // two-wire port write byte
   input wire logic sample_i, // new calibrated sample strobe
   input wire logic buf_half_i, // ring buffer half full flag
   input wire logic buf_full_i, // ring buffer three-quarter flag
   input wire logic det_event_i, // free-fall or motion event in active mode
   output logic [7:0] rdata_o, // read data
   output logic rvalid_o, // read data valid pulse
   output logic store_x_o, // store X sample to ring buffer
   output logic store_y_o, // store Y sample to ring buffer
   output logic store_z_o, // store Z sample to ring buffer
   output logic [7:0] out_cfg_o, // output config for other blocks
   output logic int_o // interrupt pin level
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic strap_ok; // strap captured after reset
      logic i2c_sel; // chosen serial port
      logic [4:0] select; // indirect selector
      logic [7:0] out_cfg; // output configuration
      logic [7:0] int_mask; // pin mask and polarity
      logic [7:0] key; // last key byte written
      logic [7:0] rdata; // read return
      logic rvalid; // read pulse
      logic sx; // store strobes
      logic sy;
      logic sz;
      logic int_pin; // pin level
   } bank_t;
   bank_t r;
   bank_t next_r;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   cfg_link_if link ();
   logic wr; // write from the active port
   logic rd; // read from the active port
   logic [5:0] addr; // address from the active port
   logic [7:0] wdata; // data from the active port
   logic int_raw; // enabled interrupt sources
   logic [7:0] sel_val; // selected indirect register
   logic [7:0] status; // status byte

   // lock tracker
   key_lock u_lock (
      .clock_i(clock_i),
      .resetn_i(resetn_i),
      .link(link)
   );

   // ring buffer decimator
   buf_decimator u_decim (
      .clock_i(clock_i),
      .resetn_i(resetn_i),
      .link(link)
   );

   always_comb begin
      if (!r.strap_ok) begin
         wr = 1'b0;
         rd = 1'b0;
         addr = spi_addr_i;
         wdata = spi_wdata_i;
      end else if (r.i2c_sel) begin
         wr = i2c_wr_i;
         rd = i2c_rd_i;
         addr = i2c_addr_i;
         wdata = i2c_wdata_i;
      end else begin
         wr = spi_wr_i;
         rd = spi_rd_i;
         addr = spi_addr_i;
         wdata = spi_wdata_i;
      end
   end

   // key writes to the tracker
   assign link.key_write = wr && (addr == `ADDR_LOCK_KEY);
   assign link.key_data = wdata;
   assign link.sample_in = sample_i;
   assign link.rate = r.out_cfg[`OC_RATE_HI:`OC_RATE_LO];

   always_comb begin
      if (r.select == `SEL_OUT_CFG) begin
         sel_val = r.out_cfg;
      end else begin
         sel_val = `BYTE_ZERO; // reserved codes read zero
      end
   end

   always_comb begin
      status = `BYTE_ZERO;
      status[`ST_LOCK_OPEN] = link.lock_open;
   end

   assign int_raw = (buf_full_i && r.int_mask[`IM_FULL_EN])
                 || (buf_half_i && r.int_mask[`IM_HALF_EN])
                 || det_event_i;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      next_r = r;
      next_r.rvalid = 1'b0;
      // capture strap once after release
      if (!r.strap_ok) begin
         next_r.strap_ok = 1'b1;
         next_r.i2c_sel = use_i2c_i;
      end
      // register writes
      if (wr) begin
         case (addr)
            `ADDR_LOCK_KEY: begin
               next_r.key = wdata;
            end
            `ADDR_INT_MASK: begin
               next_r.int_mask = wdata & `INT_MASK_MASK;
            end
            `ADDR_SELECT: begin
               next_r.select = wdata[4:0];
            end
            `ADDR_DATA_WIN: begin
               if (link.lock_open && r.select == `SEL_OUT_CFG) begin
                  next_r.out_cfg = wdata & `OUT_CFG_MASK;
               end
            end
            default: begin
               // unmapped writes dropped
            end
         endcase
      end
      // register reads
      if (rd) begin
         next_r.rvalid = 1'b1;
         case (addr)
            `ADDR_LOCK_KEY: next_r.rdata = r.key;
            `ADDR_INT_MASK: next_r.rdata = r.int_mask;
            `ADDR_SELECT: next_r.rdata = {3'h0, r.select};
            `ADDR_DATA_WIN: next_r.rdata = sel_val;
            `ADDR_STATUS: next_r.rdata = status;
            default: next_r.rdata = `BYTE_ZERO;
         endcase
      end
      next_r.sx = link.store && r.out_cfg[`OC_X_EN];
      next_r.sy = link.store && r.out_cfg[`OC_Y_EN];
      next_r.sz = link.store && r.out_cfg[`OC_Z_EN];
      if (int_raw && !r.int_mask[`IM_MASK_ALL]) begin
         next_r.int_pin = r.int_mask[`IM_POLARITY];
      end else begin
         next_r.int_pin = !r.int_mask[`IM_POLARITY];
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         r.strap_ok <= 1'b0;
         r.i2c_sel <= 1'b0;
         r.select <= `SEL_RESET;
         r.out_cfg <= `OUT_CFG_RESET;
         r.int_mask <= `INT_MASK_RESET;
         r.key <= `BYTE_ZERO;
         r.rdata <= `BYTE_ZERO;
         r.rvalid <= 1'b0;
         r.sx <= 1'b0;
         r.sy <= 1'b0;
         r.sz <= 1'b0;
         r.int_pin <= 1'b0; // idle for default active-high polarity
      end else begin
         r <= next_r;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   // slave only, no clock driven
   assign rdata_o = r.rdata;
   assign rvalid_o = r.rvalid;
   assign store_x_o = r.sx;
   assign store_y_o = r.sy;
   assign store_z_o = r.sz;
   assign out_cfg_o = r.out_cfg;
   assign int_o = r.int_pin;
endmodule : accel_config_lock_regs

// ==== dv/accel_cfg_props.sv ====
// checker for the config bank, bound onto its top module
// assumes the strap stays fixed while out of reset
`timescale 1ns/1ps
`include "accel_params.svh"
module accel_cfg_props (
   input logic clock_i, resetn_i, use_i2c_i, sample_i,
   input logic spi_wr_i, spi_rd_i, i2c_wr_i, i2c_rd_i,
   input logic [5:0] spi_addr_i, i2c_addr_i,
   input logic [7:0] spi_wdata_i, i2c_wdata_i, rdata_o, out_cfg_o,
   input logic buf_half_i, buf_full_i, det_event_i, rvalid_o,
   input logic store_x_o, store_y_o, store_z_o, int_o
);
   logic wrq, rdq, wwin, nodec, pin; // strobes of the live port
   logic [5:0] ad; // live address
   logic [7:0] wd, msk; // live data, pin mask copy
   assign wrq = use_i2c_i ? i2c_wr_i : spi_wr_i;
   assign rdq = use_i2c_i ? i2c_rd_i : spi_rd_i;
   assign ad = use_i2c_i ? i2c_addr_i : spi_addr_i;
   assign wd = use_i2c_i ? i2c_wdata_i : spi_wdata_i;
   assign wwin = wrq && ad == `ADDR_DATA_WIN;
   assign nodec = sample_i && out_cfg_o[1] == out_cfg_o[0];
   // expected pin level for the present mask and sources
   assign pin = (((buf_full_i & msk[7]) | (buf_half_i & msk[6]) | det_event_i) & !msk[1])
      ? msk[0] : !msk[0];
   // mask copy kept from the writes seen on the live port
   always_ff @(posedge clock_i) begin
      if (!resetn_i) msk <= `INT_MASK_RESET;
      else if (wrq && ad == `ADDR_INT_MASK) msk <= wd & `INT_MASK_MASK;
   end
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!resetn_i);
   AST_RD_ANSWER: assert property (rdq |=> rvalid_o)
      else $error("read not answered");
   AST_NO_SPURIOUS: assert property (!rdq |=> !rvalid_o)
      else $error("read data without a request");
   AST_RDATA_HOLD: assert property (!rvalid_o |-> $stable(rdata_o))
      else $error("read data moved without a read");
   AST_PIN: assert property ($past(resetn_i, 2) |-> int_o == $past(pin))
      else $error("interrupt pin level wrong");
   AST_STORE_CAUSE: assert property ((store_x_o || store_y_o || store_z_o) |-> $past(sample_i))
      else $error("store without a sample");
   AST_STORE_AXES: assert property ($past(sample_i) && (store_x_o || store_y_o || store_z_o)
      |-> {store_x_o, store_y_o, store_z_o} == $past(out_cfg_o[4:2]))
      else $error("axis stores disagree with enables");
   AST_NO_DECIM: assert property ($past(nodec) |-> {store_x_o, store_y_o, store_z_o}
      == $past(out_cfg_o[4:2]))
      else $error("sample dropped without rate reduction");
   AST_CFG_CAUSE: assert property (!$stable(out_cfg_o) |-> $past(wwin))
      else $error("output config changed without a window write");
   AST_CFG_RSV: assert property (out_cfg_o[7:5] == 3'h0)
      else $error("reserved config bits set");
endmodule : accel_cfg_props
bind accel_config_lock_regs accel_cfg_props accel_cfg_props_inst (.*);

// ==== dv/host_model.sv ====
// host model: bus master issuing register writes and reads
// assumes its tasks are entered just after a rising clock edge
`timescale 1ns/1ps
module host_model (
   input logic clock_i,
   input logic use_i2c_i, // strap, picks the live port
   input logic noise_i, // mirror strobes onto the idle port
   input logic rvalid_i,
   input logic [7:0] rdata_i,
   output logic spi_wr_o, spi_rd_o, i2c_wr_o, i2c_rd_o,
   output logic [5:0] spi_addr_o, i2c_addr_o,
   output logic [7:0] spi_wdata_o, i2c_wdata_o
);
   logic wr = 1'b0, rd = 1'b0; // request strobes
   logic [5:0] ad = 6'h00;
   logic [7:0] wd = 8'h00;
   logic [1:0] other; // strobes shown on the idle port
   assign other = noise_i ? {wr, rd} : 2'h0;
   assign {spi_wr_o, spi_rd_o} = use_i2c_i ? other : {wr, rd};
   assign {i2c_wr_o, i2c_rd_o} = use_i2c_i ? {wr, rd} : other;
   assign spi_addr_o = ad;
   assign i2c_addr_o = ad;
   // idle port carries inverted data so a wrong port pick shows
   assign spi_wdata_o = use_i2c_i ? ~wd : wd;
   assign i2c_wdata_o = use_i2c_i ? wd : ~wd;
   task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
      wr <= 1'b1;
      rd <= 1'b0;
      ad <= a;
      wd <= d;
      @(posedge clock_i);
   endtask : wr_reg
   task automatic rd_reg(input logic [5:0] a, output logic [7:0] q, output logic v);
      wr <= 1'b0;
      rd <= 1'b1;
      ad <= a;
      wd <= ~wd;
      @(posedge clock_i);
      rd <= 1'b0;
      ad <= ~a;
      @(posedge clock_i);
      q = rdata_i;
      v = rvalid_i;
   endtask : rd_reg
   task automatic idle();
      wr <= 1'b0;
      ad <= ~ad;
      wd <= ~wd;
      @(posedge clock_i);
   endtask : idle
endmodule : host_model

// ==== dv/testbench.sv ====
// self-checking bench for the config bank, both strap settings
// assumes the host model and the bound checker
`timescale 1ns/1ps
`include "accel_params.svh"
module testbench;
   import accel_cfg_pkg::*;
   logic clock_i = 1'b0, resetn_i = 1'b0, use_i2c_i = 1'b0, noise = 1'b0;
   logic sample_i = 1'b0, buf_half_i = 1'b0, buf_full_i = 1'b0, det_event_i = 1'b0;
   logic spi_wr_i, spi_rd_i, i2c_wr_i, i2c_rd_i, rvalid_o, int_o, v;
   logic store_x_o, store_y_o, store_z_o;
   logic [5:0] spi_addr_i, i2c_addr_i;
   logic [7:0] spi_wdata_i, i2c_wdata_i, rdata_o, out_cfg_o, q, m, r;
   int error_cnt = 0, n_checks = 0, nx, ny, nz;
   always #2.5 clock_i = ~clock_i;
   accel_config_lock_regs accel_config_lock_regs_inst (.*);
   host_model host_model_inst (.clock_i, .use_i2c_i, .noise_i(noise), .rvalid_i(rvalid_o),
      .rdata_i(rdata_o), .spi_wr_o(spi_wr_i), .spi_rd_o(spi_rd_i), .i2c_wr_o(i2c_wr_i),
      .i2c_rd_o(i2c_rd_i), .spi_addr_o(spi_addr_i), .i2c_addr_o(i2c_addr_i),
      .spi_wdata_o(spi_wdata_i), .i2c_wdata_o(i2c_wdata_i));
   // store counters, one edge behind the pulses
   always @(posedge clock_i) begin
      nx += store_x_o;
      ny += store_y_o;
      nz += store_z_o;
   end
   function automatic logic [7:0] exp_cnt(input logic en, input logic [1:0] c);
      return !en ? 8'h00 : c == `RATE_DIV4 ? 8'h02 : c == `RATE_DIV2 ? 8'h04 : 8'h08;
   endfunction : exp_cnt
   function automatic logic [7:0] exp_pin(input logic [7:0] k);
      return {7'h00, (((buf_full_i & k[7]) | (buf_half_i & k[6]) | det_event_i) & !k[1])
         ? k[0] : !k[0]};
   endfunction : exp_pin
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %0s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic w(input logic [5:0] a, input logic [7:0] d);
      host_model_inst.wr_reg(a, d);
   endtask : w
   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      host_model_inst.rd_reg(a, q, v);
      chk("rvalid", 8'h01, {7'h00, v});
      chk("rdata", e, q);
   endtask : rd
   task automatic key(input logic [7:0] k2);
      w(`ADDR_LOCK_KEY, `KEY_BYTE0);
      w(`ADDR_LOCK_KEY, `KEY_BYTE1);
      w(`ADDR_LOCK_KEY, k2);
   endtask : key
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : report_and_stop
   // watchdog, far beyond the expected run
   initial begin
      #20000;
      error_cnt++;
      report_and_stop();
   end
   initial begin
      void'($urandom(30375));
      for (int s = 0; s < 2; s++) begin
         resetn_i <= 1'b0;
         use_i2c_i <= s[0];
         repeat (6) @(posedge clock_i);
         resetn_i <= 1'b1;
         repeat (2) @(posedge clock_i);
         chk("out_cfg", `OUT_CFG_RESET, out_cfg_o);
         rd(`ADDR_INT_MASK, `INT_MASK_RESET);
         rd(`ADDR_STATUS, 8'h00);
         rd(`ADDR_LOCK_KEY, 8'h00);
         rd(6'h3f, 8'h00);
         $display("test reset done");
         r = 8'($urandom);
         w(`ADDR_SELECT, {3'h0, `SEL_OUT_CFG});
         w(`ADDR_DATA_WIN, r);
         rd(`ADDR_DATA_WIN, `OUT_CFG_RESET);
         key(8'h55);
         rd(`ADDR_STATUS, 8'h00);
         key(`KEY_BYTE2);
         rd(`ADDR_STATUS, 8'h01);
         w(`ADDR_DATA_WIN, r);
         rd(`ADDR_DATA_WIN, r & `OUT_CFG_MASK);
         chk("out_cfg", r & `OUT_CFG_MASK, out_cfg_o);
         $display("test lock done");
         for (int c = 0; c < 4; c++) begin
            m = {3'h0, 3'($urandom), 2'(c)};
            w(`ADDR_DATA_WIN, m);
            host_model_inst.idle();
            nx = 0;
            ny = 0;
            nz = 0;
            repeat (8) begin
               sample_i <= 1'b1;
               @(posedge clock_i);
               sample_i <= 1'b0;
               @(posedge clock_i);
            end
            repeat (2) @(posedge clock_i);
            chk("store_x", exp_cnt(m[4], m[1:0]), 8'(nx));
            chk("store_y", exp_cnt(m[3], m[1:0]), 8'(ny));
            chk("store_z", exp_cnt(m[2], m[1:0]), 8'(nz));
         end
         w(`ADDR_LOCK_KEY, 8'h12);
         w(`ADDR_DATA_WIN, 8'h00);
         rd(`ADDR_DATA_WIN, m);
         $display("test decimation done");
         noise <= 1'b1;
         for (int i = 0; i < 16; i++) begin
            m = 8'($urandom);
            m[1] = i[0] & i[1];
            w(`ADDR_INT_MASK, m);
            {buf_full_i, buf_half_i, det_event_i} <= 3'($urandom);
            host_model_inst.idle();
            @(posedge clock_i);
            chk("int_pin", exp_pin(m), {7'h00, int_o});
            rd(`ADDR_INT_MASK, m & `INT_MASK_MASK);
         end
         noise <= 1'b0;
         {buf_full_i, buf_half_i, det_event_i} <= 3'h0;
         $display("test interrupt done");
      end
      report_and_stop();
   end
endmodule : testbench
